// ===== logic/amp_mode_and_protection_ctrl.v
// mode latch and protection sequencing of a two-channel class-d amplifier
`include "amp_ctrl_defs.vh"
`timescale 1ns/100ps

// Behaviour
// (R1) latch strap decode when switching first starts
// (R2) 100k: parallel or AD; open: BD
// (R3) short, 4k7, 13k, 33k decode per table
// (R4) modulation from strap, or host bit
// (R5) AD opposite phase; BD in phase, inverted
// (R6) phase shift only in slave with lock
// (R7) host selects quarter shift only with capacitor
// (R8) parallel drives both stages from channel 1
// (R9) foldback lowers gain, amplifier keeps running
// (R10) overtemperature stops power stage at once
// (R11) current limit regulates, outputs keep switching
// (R12) short switches channel off, retry each 50 ms
// (R13) supply short blocks retry until cleared
// (R14) start-up waits while outputs show short
// (R15) offset guard active in mute and operate
// (R16) i2c: alarm flag, optional report, optional stop
// (R17) offset stop latched until enable toggled
// (R18) non-i2c: offset always reports and stops
// (R19) undervoltage mutes then stops, auto restart
// (R20) overvoltage stops stages, auto restart
// (R21) i2c deep drop stays off until command
// (R22) synchronise comparators; retry from clock counter
module amp_mode_and_protection_ctrl #(
	parameter RETRY_CYCLES = `RETRY_CYCLES
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rstn,
	// configuration pins and straps
	input  wire       i2c_mode,
	input  wire [2:0] strap_code,
	input  wire       clock_slave,
	input  wire       phase_lock_on,
	input  wire       offset_guard_enable,
	// host control bits
	input  wire       start_request,
	input  wire       mute_request,
	input  wire       host_mod_bd,
	input  wire [2:0] phase_shift_select,
	input  wire       ch1_enable,
	input  wire       ch2_enable,
	input  wire       offset_report_on,
	input  wire       offset_stop_bypass,
	input  wire       host_restart,
	input  wire       offset_flag_clear,
	// analog comparator flags
	input  wire       heat_warn_cmp,
	input  wire       heat_trip_cmp,
	input  wire [1:0] over_current_cmp,
	input  wire [1:0] load_short_cmp,
	input  wire [1:0] supply_short_cmp,
	input  wire       output_short_cmp,
	input  wire       offset_cmp,
	input  wire       low_supply_cmp,
	input  wire       deep_drop_cmp,
	input  wire       high_supply_cmp,
	// mode outputs
	output reg        mode_latched,
	output reg        parallel_mode,
	output reg        mod_bd,
	output reg        invert_second_half,
	output reg        halves_opposite,
	output reg  [2:0] phase_shift,
	// power stage control
	output reg  [1:0] stage_enable,
	output reg  [1:0] stage_switching,
	output reg        mute,
	output reg        heat_foldback,
	output reg  [1:0] current_limit_guard,
	// status
	output reg        offset_alarm_flag,
	output reg        offset_latched,
	output reg        power_up_clear,
	output reg        fault_flag_pin_o,
	output reg        fault_flag_pin_oe
);

	// ==========================================================
	// comparator synchronisers
	wire [12:0] cmp_raw;
	wire [12:0] cmp;
	assign cmp_raw = {high_supply_cmp, deep_drop_cmp, low_supply_cmp,
		offset_cmp, output_short_cmp, supply_short_cmp,
		load_short_cmp, over_current_cmp, heat_trip_cmp,
		heat_warn_cmp};

	sync2 #(.WIDTH(13)) u_cmp_sync (
		.ref_clk(ref_clk),
		.rstn   (rstn),
		.din    (cmp_raw),
		.dout   (cmp)
	); // R22

	wire       s_heat_warn   = cmp[0];
	wire       s_heat_trip   = cmp[1];
	wire [1:0] s_ocp         = cmp[3:2];
	wire [1:0] s_load_short  = cmp[5:4];
	wire [1:0] s_supply_shrt = cmp[7:6];
	wire       s_out_short   = cmp[8];
	wire       s_offset      = cmp[9];
	wire       s_low_supply  = cmp[10];
	wire       s_deep_drop   = cmp[11];
	wire       s_high_supply = cmp[12];

	// pin and host levels also cross from outside the clock
	wire [18:0] pin_raw;
	wire [18:0] pin_s;
	assign pin_raw = {offset_flag_clear, host_restart, offset_stop_bypass,
		offset_report_on, ch2_enable, ch1_enable, phase_shift_select,
		host_mod_bd, mute_request, start_request, offset_guard_enable,
		phase_lock_on, clock_slave, strap_code, i2c_mode};

	sync2 #(.WIDTH(19)) u_pin_sync (
		.ref_clk(ref_clk),
		.rstn   (rstn),
		.din    (pin_raw),
		.dout   (pin_s)
	);

	wire       s_i2c       = pin_s[0];
	wire [2:0] s_strap     = pin_s[3:1];
	wire       s_slave     = pin_s[4];
	wire       s_lock      = pin_s[5];
	wire       s_dc_en     = pin_s[6];
	wire       s_start     = pin_s[7];
	wire       s_mute_req  = pin_s[8];
	wire       s_host_bd   = pin_s[9];
	wire [2:0] s_shift_sel = pin_s[12:10];
	wire       s_ch1_en    = pin_s[13];
	wire       s_ch2_en    = pin_s[14];
	wire       s_rep_on    = pin_s[15];
	wire       s_bypass    = pin_s[16];
	wire       s_restart   = pin_s[17];
	wire       s_flag_clr  = pin_s[18];

	// ==========================================================
	// strap decode
	// returns {parallel, mod_bd, half_shift}
	function [2:0] strap_decode;
		input [2:0] code;
		input       i2c;
		begin
			case (code)
			`STRAP_SHORT: strap_decode = 3'h0; // R3
			`STRAP_4K7:   strap_decode = 3'h2; // R3
			`STRAP_13K:   strap_decode = 3'h1; // R3
			`STRAP_33K:   strap_decode = 3'h3; // R3
			`STRAP_100K:  strap_decode = i2c ? 3'h4 : 3'h0; // R2
			`STRAP_OPEN:  strap_decode = 3'h2; // R2
			default:      strap_decode = 3'h0;
			endcase
			// only the parallel choice survives in i2c mode
			if (i2c)
				strap_decode = strap_decode & 3'h4;
		end
	endfunction

	reg       strap_par;
	reg       strap_bd;
	reg       strap_half;
	reg       strap_i2c;

	// ==========================================================
	// start-up state machine
	localparam ST_OFF     = 3'h0;
	localparam ST_CHECK   = 3'h1;
	localparam ST_MUTE    = 3'h2;
	localparam ST_RUN     = 3'h3;
	localparam ST_STOPPED = 3'h4;

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg        start_prev;
	reg        restart_prev;
	reg  [1:0] settle;

	wire hard_stop = s_heat_trip | s_high_supply | offset_latched
		| power_up_clear | s_low_supply; // R10 R20 R19
	wire enable_on = s_i2c ? s_start : 1'b1;
	wire enable_rise = s_start & ~start_prev;

	always @* begin
		next_state = state;
		case (state)
		ST_OFF:
			if (enable_on && !hard_stop && settle[1])
				next_state = ST_CHECK;
		ST_CHECK:
			if (hard_stop || !enable_on)
				next_state = ST_OFF;
			else if (!s_out_short)
				next_state = ST_MUTE; // R14
		ST_MUTE:
			if (hard_stop || !enable_on)
				next_state = ST_OFF;
			else if (!s_mute_req)
				next_state = ST_RUN;
		ST_RUN:
			if (hard_stop || !enable_on)
				next_state = ST_OFF;
			else if (s_mute_req)
				next_state = ST_MUTE;
		ST_STOPPED:
			next_state = ST_OFF;
		default:
			next_state = ST_OFF;
		endcase
	end

	wire switching_now = (state == ST_MUTE) || (state == ST_RUN);

	// ==========================================================
	// per-channel short handling
	wire [1:0] chan_off;

	chan_retry #(.RETRY_CYCLES(RETRY_CYCLES)) u_retry1 (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.short_seen  (s_load_short[0] & switching_now),
		.supply_short(s_supply_shrt[0]),
		.chan_off    (chan_off[0]),
		.window_hold ()
	); // R12 R13

	chan_retry #(.RETRY_CYCLES(RETRY_CYCLES)) u_retry2 (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.short_seen  (s_load_short[1] & switching_now),
		.supply_short(s_supply_shrt[1]),
		.chan_off    (chan_off[1]),
		.window_hold ()
	); // R12 R13

	// ==========================================================
	// offset guard
	wire offset_trip = s_offset & s_dc_en & switching_now; // R15
	wire offset_stops = s_i2c ? ~s_bypass : 1'b1; // R16 R18
	wire offset_reports = s_i2c ? s_rep_on : 1'b1; // R16 R18

	// ==========================================================
	// registered behaviour
	reg  [1:0] want;
	reg        chan2_src;
	wire       next_mod_bd = strap_i2c ? s_host_bd : strap_bd; // R4

	always @* begin
		chan2_src = parallel_mode ? s_ch1_en : s_ch2_en; // R8
		want = {chan2_src, s_ch1_en | ~s_i2c};
		if (!s_i2c)
			want[1] = 1'b1;
	end

	always @(posedge ref_clk) begin
		if (!rstn) begin
			state               <= ST_OFF;
			start_prev          <= 1'b0;
			restart_prev        <= 1'b0;
			settle              <= 2'h0;
			mode_latched        <= 1'b0;
			strap_par           <= 1'b0;
			strap_bd            <= 1'b0;
			strap_half          <= 1'b0;
			strap_i2c           <= 1'b0;
			parallel_mode       <= 1'b0;
			mod_bd              <= `MOD_AD;
			invert_second_half  <= 1'b0;
			halves_opposite     <= 1'b1;
			phase_shift         <= `SHIFT_NONE;
			stage_enable        <= 2'h0;
			stage_switching     <= 2'h0;
			mute                <= 1'b1;
			heat_foldback       <= 1'b0;
			current_limit_guard <= 2'h0;
			offset_alarm_flag   <= 1'b0;
			offset_latched      <= 1'b0;
			power_up_clear      <= 1'b0;
			fault_flag_pin_o    <= 1'b0;
			fault_flag_pin_oe   <= 1'b0;
		end else begin
			state        <= next_state;
			start_prev   <= s_start;
			restart_prev <= s_restart;
			// synchronisers show reset zeros for two edges; no start before
			settle       <= settle[1] ? settle : settle + 2'h1;

			// capture once, when outputs first switch
			if (!mode_latched && next_state == ST_MUTE) begin
				mode_latched <= 1'b1; // R1
				{strap_par, strap_bd, strap_half}
					<= strap_decode(s_strap, s_i2c); // R1
				strap_i2c    <= s_i2c;
			end

			parallel_mode <= mode_latched & strap_par; // R2
			// all three from one source, so they never disagree
			mod_bd             <= next_mod_bd; // R4
			halves_opposite    <= (next_mod_bd == `MOD_AD); // R5
			invert_second_half <= (next_mod_bd == `MOD_BD); // R5

			if (!(s_slave && s_lock))
				phase_shift <= `SHIFT_NONE; // R6
			else if (strap_i2c)
				// values beyond the five shifts fall back to none
				phase_shift <= (s_shift_sel > `SHIFT_MAX) ?
					`SHIFT_NONE : s_shift_sel; // R6 R7
			else
				phase_shift <= strap_half ? `SHIFT_HALF : `SHIFT_NONE;

			// gain reduction only, never a stop
			heat_foldback <= s_heat_warn; // R9
			current_limit_guard <= s_ocp & {2{switching_now}}; // R11

			stage_enable    <= {2{switching_now}} & ~chan_off
				& want; // R10 R12
			stage_switching <= {2{switching_now}} & ~chan_off
				& want;
			// undervoltage forces mute ahead of the stop
			mute <= ~(state == ST_RUN) | s_low_supply; // R19

			// offset: set wins over clear
			if (offset_trip && s_i2c)
				offset_alarm_flag <= 1'b1; // R16
			else if (s_i2c && s_flag_clr)
				offset_alarm_flag <= 1'b0;

			if (offset_trip && offset_stops)
				offset_latched <= 1'b1; // R16 R18
			else if (enable_rise || !s_dc_en || !enable_on)
				offset_latched <= 1'b0; // R17

			if (s_i2c && s_deep_drop)
				power_up_clear <= 1'b1; // R21
			else if (s_restart && !restart_prev)
				power_up_clear <= 1'b0; // R21

			// open drain: drive low while a fault stands
			fault_flag_pin_o  <= 1'b0;
			fault_flag_pin_oe <= s_heat_trip | s_high_supply
				| s_low_supply | (|chan_off) | power_up_clear
				| ((offset_trip | offset_latched)
				& offset_reports); // R16 R18
		end
	end

endmodule // amp_mode_and_protection_ctrl

// ===== logic/amp_ctrl_defs.vh
// constants for the amplifier mode and protection controller
`ifndef AMP_CTRL_DEFS_VH
`define AMP_CTRL_DEFS_VH

// ==========================================================
// strap decode codes (from the strap resistor comparator bank)
`define STRAP_SHORT      3'h0
`define STRAP_4K7        3'h1
`define STRAP_13K        3'h2
`define STRAP_33K        3'h3
`define STRAP_100K       3'h4
`define STRAP_OPEN       3'h5

// ==========================================================
// modulation and phase shift encodings
`define MOD_AD           1'b0
`define MOD_BD           1'b1
`define SHIFT_NONE       3'h0
`define SHIFT_QUARTER    3'h1
`define SHIFT_HALF       3'h2
`define SHIFT_MAX        3'h5

// ==========================================================
// timing
`define CLK_PERIOD_PS    5000
`define RETRY_MS         50
// per-ms count first, so the product stays inside 32 bits
`define RETRY_CYCLES     (`RETRY_MS * (1000000000 / `CLK_PERIOD_PS))

`endif

// ===== logic/sync2.v
// two flip-flop synchroniser for a bundle of level signals
`timescale 1ns/100ps

module sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             rstn,
	// data
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] stage;

	always @(posedge ref_clk) begin
		if (!rstn) begin
			stage <= {WIDTH{1'b0}};
			dout  <= {WIDTH{1'b0}};
		end else begin
			stage <= din;
			dout  <= stage;
		end
	end

endmodule // sync2

// ===== logic/chan_retry.v
// per-channel short circuit shutdown with timed retry
`include "amp_ctrl_defs.vh"
`timescale 1ns/100ps

module chan_retry #(
	parameter RETRY_CYCLES = `RETRY_CYCLES
) (
	// clock and reset
	input  wire ref_clk,
	input  wire rstn,
	// fault inputs, already synchronised
	input  wire short_seen,
	input  wire supply_short,
	// state
	output reg  chan_off,
	output reg  window_hold
);

	localparam CW = 32;
	localparam [CW-1:0] RETRY_LAST = RETRY_CYCLES - 1;
	reg [CW-1:0] count;

	always @(posedge ref_clk) begin
		if (!rstn) begin
			chan_off    <= 1'b0;
			window_hold <= 1'b0;
			count       <= {CW{1'b0}};
		end else if (!chan_off) begin
			if (short_seen) begin
				chan_off    <= 1'b1; // R12
				window_hold <= supply_short; // R13
				count       <= {CW{1'b0}};
			end
		end else if (count < RETRY_LAST) begin
			count <= count + 1'b1; // R22
		end else if (window_hold && supply_short) begin
			// hold at the retry point until the supply short clears
			count <= count; // R13
		end else begin
			// retry; a lasting short trips again next cycle
			chan_off    <= 1'b0; // R12
			window_hold <= 1'b0;
			count       <= {CW{1'b0}};
		end
	end

endmodule // chan_retry

// ===== bench/amp_ctrl_chk.sv
// port assertions of the amplifier mode and protection controller
`timescale 1ns/100ps
module amp_ctrl_chk (
	// clock and reset
	input wire       ref_clk,
	input wire       rstn,
	// pins and comparators
	input wire       i2c_mode,
	input wire       clock_slave,
	input wire       phase_lock_on,
	input wire       heat_warn_cmp,
	input wire       heat_trip_cmp,
	input wire       low_supply_cmp,
	input wire       high_supply_cmp,
	// outputs
	input wire       mode_latched,
	input wire       parallel_mode,
	input wire       mod_bd,
	input wire       invert_second_half,
	input wire       halves_opposite,
	input wire [2:0] phase_shift,
	input wire [1:0] stage_enable,
	input wire [1:0] stage_switching,
	input wire       mute,
	input wire       heat_foldback,
	input wire       offset_latched,
	input wire       fault_flag_pin_oe
);
	// =====
	// run lengths; six cycles covers the synchroniser and output latency
	wire [4:0] lvl = {high_supply_cmp, low_supply_cmp, heat_trip_cmp,
		heat_warn_cmp, !(clock_slave && phase_lock_on)};
	reg  [2:0] run [0:4];
	integer    i;
	always @(posedge ref_clk) begin
		for (i = 0; i < 5; i = i + 1)
			run[i] <= (!rstn || !lvl[i]) ? 3'h0 :
				((run[i] == 3'h7) ? run[i] : run[i] + 3'h1);
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	mode_hold_a: assert property (
		mode_latched && $past(mode_latched, 2) |-> $stable(parallel_mode))
		else $error("parallel mode moved after latch");
	mod_halves_a: assert property (
		halves_opposite != mod_bd && invert_second_half == mod_bd)
		else $error("bridge phasing wrong");
	shift_gate_a: assert property (run[0] >= 3'h6 |-> phase_shift == 3'h0)
		else $error("shift without slave lock");
	fold_on_a: assert property (run[1] >= 3'h6 |-> heat_foldback)
		else $error("no foldback");
	heat_stop_a: assert property (
		run[2] >= 3'h6 |-> stage_switching == 2'h0)
		else $error("still switching when hot");
	low_supply_a: assert property (
		run[3] >= 3'h6 |-> mute && stage_switching == 2'h0)
		else $error("no stop on low supply");
	high_supply_a: assert property (
		run[4] >= 3'h6 |-> stage_enable == 2'h0)
		else $error("no stop on high supply");
	offset_pin_a: assert property (
		offset_latched && $past(offset_latched, 2) && !i2c_mode
		|-> fault_flag_pin_oe)
		else $error("offset trip not on fault pin");
endmodule // amp_ctrl_chk

bind amp_mode_and_protection_ctrl amp_ctrl_chk i_amp_ctrl_chk (.*);

// ===== bench/host_model.sv
// host side model driving the control bits
`timescale 1ns/100ps
`include "amp_ctrl_defs.vh"
module host_model #(
	parameter CAP_FITTED = 0
) (
	// clock
	input  wire       ref_clk,
	// bench requests
	input  wire [2:0] want_shift,
	input  wire       auto_restart,
	// device state
	input  wire       parallel_mode,
	input  wire       ch1_enable,
	input  wire       power_up_clear,
	// control bits
	output reg  [2:0] phase_shift_select = 3'h0,
	output reg        ch2_enable = 1'b0,
	output reg        host_restart = 1'b0
);
	always @(negedge ref_clk) begin
		// quarter shift only with the extra loop capacitor fitted
		phase_shift_select <= (want_shift == `SHIFT_QUARTER && !CAP_FITTED) ?
			`SHIFT_HALF : want_shift;
		// parallel: only channel 1 bits written, ch2_enable held low
		ch2_enable <= ch1_enable && !parallel_mode;
		host_restart <= power_up_clear && auto_restart;
	end
endmodule // host_model

// ===== bench/tb.sv
// self-checking bench of the amplifier mode and protection controller
`timescale 1ns/100ps
`include "amp_ctrl_defs.vh"
module tb;
	// =====
	// stimulus and observation
	reg ref_clk = 1'b0, rstn = 1'b0, i2c_mode = 1'b0, clock_slave = 1'b1;
	reg phase_lock_on = 1'b1, offset_guard_enable = 1'b1, host_mod_bd = 1'b0;
	reg start_request = 1'b1, mute_request = 1'b0, ch1_enable = 1'b1;
	reg offset_report_on = 1'b1, offset_stop_bypass = 1'b0, offset_cmp = 1'b0;
	reg offset_flag_clear = 1'b0, output_short_cmp = 1'b0, auto_restart = 1'b1;
	reg deep_drop_cmp = 1'b0;
	reg [2:0] strap_code = 3'h0, want_shift = 3'h0;
	reg [1:0] load_short_cmp = 2'h0, supply_short_cmp = 2'h0;
	reg [4:0] flt = 5'h0;
	reg [31:0] rnd;
	wire [1:0] over_current_cmp = {2{flt[0]}};
	wire heat_warn_cmp = flt[1], heat_trip_cmp = flt[2];
	wire low_supply_cmp = flt[3], high_supply_cmp = flt[4];
	wire mode_latched, parallel_mode, mod_bd, invert_second_half, mute;
	wire halves_opposite, heat_foldback, offset_alarm_flag, offset_latched;
	wire power_up_clear, fault_flag_pin_o, fault_flag_pin_oe;
	wire ch2_enable, host_restart;
	wire [2:0] phase_shift, phase_shift_select;
	wire [1:0] stage_enable, stage_switching, current_limit_guard;
	// open drain with pull-up
	wire fault_flag_pin = fault_flag_pin_oe ? fault_flag_pin_o : 1'b1;
	integer seed = 25, mismatches = 0, tests_run = 0, m, c, k;

	amp_mode_and_protection_ctrl #(.RETRY_CYCLES(20))
		i_amp_mode_and_protection_ctrl (.*);
	host_model i_host_model (.*);
	always #2.5 ref_clk = ~ref_clk;

	task check(input [7:0] seen, input [7:0] exp); begin
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end endtask
	task wt(input integer n); begin
		repeat (n) @(negedge ref_clk);
	end endtask
	task tally_and_finish; begin
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end endtask
	// start-up is held off while the outputs show a short
	task boot(input md, input [2:0] cd); begin
		rstn = 1'b0;
		i2c_mode = md;
		strap_code = cd;
		output_short_cmp = 1'b1;
		wt(16);
		rstn = 1'b1;
		wt(20);
		check(stage_enable, 2'h0);
		output_short_cmp = 1'b0;
		wt(20);
	end endtask
	function [3:0] exp_flt(input integer f); begin
		exp_flt = (f == 0) ? 4'hd : ((f == 1) ? 4'he : 4'h0);
	end endfunction

	initial begin
		for (m = 1; m >= 0; m = m - 1) begin
			for (c = 0; c < 6; c = c + 1) begin
				rnd = $random(seed);
				host_mod_bd = rnd[3];
				want_shift = rnd[2:0];
				boot(m[0], c[2:0]);
				check(mode_latched, 1'b1);
				check(stage_switching, 2'h3);
				check(parallel_mode, m == 1 && c == 4);
				check(mod_bd, m ? host_mod_bd : c[0]);
				check(phase_shift, m ? ((phase_shift_select > `SHIFT_MAX) ?
					3'h0 : phase_shift_select) : {1'b0, c == 2 || c == 3, 1'b0});
				strap_code = c[2:0] ^ 3'h1;
				wt(10);
				check({parallel_mode, mod_bd},
					{m == 1 && c == 4, m ? host_mod_bd : c[0]});
			end
		end
		clock_slave = 1'b0;
		wt(10);
		check(phase_shift, 3'h0);
		for (k = 0; k < 5; k = k + 1) begin
			flt = 5'h1 << k;
			wt(10);
			check({stage_switching, heat_foldback, current_limit_guard[0]},
				exp_flt(k));
			check(mute, k >= 2);
			check(current_limit_guard, {2{k == 0}});
			flt = 5'h0;
			wt(40);
			check(stage_switching, 2'h3);
		end
		// short on channel 1: off for the retry interval, then back
		load_short_cmp = 2'h1;
		wt(6);
		load_short_cmp = 2'h0;
		wt(6);
		check(stage_enable, 2'h2);
		wt(30);
		check(stage_enable, 2'h3);
		load_short_cmp = 2'h2;
		supply_short_cmp = 2'h2;
		wt(6);
		load_short_cmp = 2'h0;
		wt(40);
		check(stage_enable, 2'h1);
		supply_short_cmp = 2'h0;
		wt(40);
		check(stage_enable, 2'h3);
		offset_cmp = 1'b1;
		wt(6);
		offset_cmp = 1'b0;
		wt(30);
		check({offset_latched, stage_enable, fault_flag_pin}, 4'h8);
		offset_guard_enable = 1'b0;
		wt(10);
		check(offset_latched, 1'b0);
		offset_guard_enable = 1'b1;
		offset_stop_bypass = 1'b1;
		boot(1'b1, 3'h0);
		offset_cmp = 1'b1;
		wt(8);
		check({offset_alarm_flag, fault_flag_pin, stage_switching}, 4'hb);
		offset_cmp = 1'b0;
		offset_stop_bypass = 1'b0;
		wt(10);
		offset_cmp = 1'b1;
		wt(6);
		offset_cmp = 1'b0;
		wt(10);
		check(stage_enable, 2'h0);
		offset_flag_clear = 1'b1;
		wt(6);
		check(offset_alarm_flag, 1'b0);
		offset_flag_clear = 1'b0;
		start_request = 1'b0;
		wt(10);
		start_request = 1'b1;
		wt(40);
		check({offset_latched, stage_enable}, 3'h3);
		auto_restart = 1'b0;
		deep_drop_cmp = 1'b1;
		wt(6);
		deep_drop_cmp = 1'b0;
		wt(40);
		check({power_up_clear, stage_enable}, 3'h4);
		auto_restart = 1'b1;
		wt(40);
		check({power_up_clear, stage_enable}, 3'h3);
		tally_and_finish;
	end
	// hang guard, well beyond the roughly 1460 cycles the run needs
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches = mismatches + 1;
		tally_and_finish;
	end
endmodule // tb
